//--- logic/oscst_cfg.svh
// Offsets, field positions, reset values and counts of the stabilization block
`ifndef OSCST_CFG_SVH
`define OSCST_CFG_SVH

`define OSCST_ADDR_W 20
`define OSCST_STATUS_ADDR 20'hfffa2
`define OSCST_SELECT_ADDR 20'hfffa3
`define OSCST_STATUS_RESET 8'h00
`define OSCST_SELECT_RESET 3'h7
`define OSCST_SELECT_W 3
`define OSCST_STATUS_W 8
`define OSCST_CNT_W 19
`define OSCST_EXP_0 5'h08
`define OSCST_EXP_1 5'h09
`define OSCST_EXP_2 5'h0a
`define OSCST_EXP_3 5'h0b
`define OSCST_EXP_4 5'h0d
`define OSCST_EXP_5 5'h0f
`define OSCST_EXP_6 5'h11
`define OSCST_EXP_7 5'h12

`endif

//--- logic/oscst_cnt_if.sv
// Link between the control logic and the stabilization counter
`timescale 1ns/1ns
`include "oscst_cfg.svh"
interface oscst_cnt_if;
    import oscst_pkg::*;
    logic clear;
    logic tick;
    oscst_code_t limit_code;
    logic [`OSCST_STATUS_W-1:0] status;
    logic done;

    modport ctrl (output clear, output tick, output limit_code, input status, input done);
    modport cnt (input clear, input tick, input limit_code, output status, output done);
endinterface : oscst_cnt_if

//--- logic/oscst_counter.sv
// Crystal period counter with thermometer status
`timescale 1ns/1ns
`include "oscst_cfg.svh"
module oscst_counter
    import oscst_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    oscst_cnt_if.cnt cnt_if
);
    oscst_cnt_t count_q;
    logic [`OSCST_STATUS_W-1:0] status_q;
    oscst_cnt_t limit;

    assign limit = oscst_limit(cnt_if.limit_code);
    assign cnt_if.status = status_q;
    assign cnt_if.done = (count_q >= limit);

    // Restart on clear, saturate at selected limit
    always_ff @(posedge clock) begin
        if (srst || cnt_if.clear) begin
            count_q <= '0;
        end else if (cnt_if.tick && (count_q < limit)) begin
            count_q <= count_q + oscst_cnt_t'(1);
        end
    end

    // Bit 7 is the shortest time; bits only set, until clear or reset zeroes them all
    always_ff @(posedge clock) begin
        if (srst || cnt_if.clear) begin
            status_q <= `OSCST_STATUS_RESET;
        end else begin
            for (int i = 0; i < `OSCST_STATUS_W; i++) begin
                if (count_q >= oscst_limit(oscst_code_t'(i))) begin
                    status_q[`OSCST_STATUS_W-1-i] <= 1'b1;
                end
            end
        end
    end
endmodule : oscst_counter

//--- logic/oscst_pkg.sv
// Types and helpers of the stabilization block
`include "oscst_cfg.svh"
package oscst_pkg;
    typedef logic [`OSCST_SELECT_W-1:0] oscst_code_t;
    typedef logic [`OSCST_CNT_W-1:0] oscst_cnt_t;

    typedef enum logic [1:0] {
        OSCST_RUN = 2'b00,
        OSCST_STOPPED = 2'b01,
        OSCST_HOLD = 2'b10
    } oscst_mode_e;

    // Wait code to power of two of crystal periods
    function automatic logic [4:0] oscst_exp(input oscst_code_t code);
        logic [4:0] e;
        e = `OSCST_EXP_7;
        unique case (code)
            3'h0: e = `OSCST_EXP_0;
            3'h1: e = `OSCST_EXP_1;
            3'h2: e = `OSCST_EXP_2;
            3'h3: e = `OSCST_EXP_3;
            3'h4: e = `OSCST_EXP_4;
            3'h5: e = `OSCST_EXP_5;
            3'h6: e = `OSCST_EXP_6;
            3'h7: e = `OSCST_EXP_7;
        endcase
        return e;
    endfunction : oscst_exp

    function automatic oscst_cnt_t oscst_limit(input oscst_code_t code);
        return oscst_cnt_t'(1) << oscst_exp(code);
    endfunction : oscst_limit
endpackage : oscst_pkg

//--- logic/oscst_top.sv
// Crystal oscillation stabilization counter, status and wait select
`timescale 1ns/1ns
`include "oscst_cfg.svh"
module oscst_top
    import oscst_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [`OSCST_ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_wr_bit,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    input wire logic stop_exec,
    input wire logic stop_release,
    input wire logic main_osc_stop_set,
    input wire logic cpu_on_crystal,
    input wire logic main_crystal_clock,
    output logic cpu_hold,
    output logic crystal_osc_enable,
    output logic onchip_osc_enable
);
    oscst_cnt_if cnt_if ();

    logic xtal_s1_q;
    logic xtal_s2_q;
    logic xtal_s3_q;
    oscst_code_t select_q;
    oscst_mode_e mode_q;
    logic [7:0] rdata_q;
    logic hold_q;
    logic xosc_en_q;
    logic ioosc_en_q;

    // Decoded strobes and events
    logic xtal_rise;
    logic count_allowed;
    logic status_clear;
    logic hit_status;
    logic hit_select;
    logic rd_status;
    logic rd_select;
    logic wr_select;
    logic [7:0] select_rd;
    logic [7:0] read_value;
    logic stop_enter;
    logic stop_leave;
    logic leave_to_hold;
    logic leave_to_run;

    // Crystal clock is asynchronous: two-stage sync
    // Crystal must stay below half of clock to be seen
    always_ff @(posedge clock) begin
        if (srst) begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
        end else begin
            xtal_s1_q <= main_crystal_clock;
            xtal_s2_q <= xtal_s1_q;
        end
    end

    // Previous synchronised level for edge detect
    always_ff @(posedge clock) begin
        if (srst) begin
            xtal_s3_q <= 1'b0;
        end else begin
            xtal_s3_q <= xtal_s2_q;
        end
    end

    // Only real crystal edges advance the count, never while stopped
    assign xtal_rise = xtal_s2_q && !xtal_s3_q;
    assign count_allowed = (mode_q != OSCST_STOPPED);
    assign cnt_if.tick = xtal_rise && count_allowed;
    assign status_clear = stop_exec || main_osc_stop_set;
    assign cnt_if.clear = status_clear;
    assign cnt_if.limit_code = select_q;

    oscst_counter u_counter (
        .clock(clock),
        .srst(srst),
        .cnt_if(cnt_if)
    );

    // Register decode
    assign hit_status = (mem_addr == `OSCST_STATUS_ADDR);
    assign hit_select = (mem_addr == `OSCST_SELECT_ADDR);
    assign rd_status = mem_rd && hit_status;
    assign rd_select = mem_rd && hit_select;
    assign wr_select = mem_wr && !mem_wr_bit && hit_select;
    assign select_rd = {5'h00, select_q};

    // Wait select: byte writes only, bit writes ignored
    always_ff @(posedge clock) begin
        if (srst) begin
            select_q <= `OSCST_SELECT_RESET;
        end else if (wr_select) begin
            select_q <= mem_wdata[`OSCST_SELECT_W-1:0];
        end
    end

    // Status writes have no effect; idle and unmapped reads give zero
    always_comb begin
        read_value = 8'h00;
        if (rd_status) begin
            read_value = cnt_if.status;
        end else if (rd_select) begin
            read_value = select_rd;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= read_value;
        end
    end

    // STOP entry and exit as seen by the sequencer
    assign stop_enter = stop_exec && (mode_q == OSCST_RUN);
    assign stop_leave = stop_release && (mode_q == OSCST_STOPPED);
    assign leave_to_hold = stop_leave && cpu_on_crystal;
    assign leave_to_run = stop_leave && !cpu_on_crystal;

    // STOP sequencing around the stabilization wait
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_q <= OSCST_RUN;
        end else begin
            unique case (mode_q)
                OSCST_RUN: begin
                    if (stop_enter) begin
                        mode_q <= OSCST_STOPPED;
                    end
                end
                OSCST_STOPPED: begin
                    if (leave_to_hold) begin
                        mode_q <= OSCST_HOLD;
                    end else if (leave_to_run) begin
                        mode_q <= OSCST_RUN;
                    end
                end
                OSCST_HOLD: begin
                    if (cnt_if.done) begin
                        mode_q <= OSCST_RUN;
                    end
                end
                default: begin
                    mode_q <= OSCST_RUN;
                end
            endcase
        end
    end

    // CPU hold: raised in STOP, kept through the crystal wait
    always_ff @(posedge clock) begin
        if (srst) begin
            hold_q <= 1'b0;
        end else begin
            unique case (mode_q)
                OSCST_RUN: begin
                    hold_q <= stop_enter;
                end
                OSCST_STOPPED: begin
                    // Only a wake on the on-chip clock drops it here
                    hold_q <= !leave_to_run;
                end
                OSCST_HOLD: begin
                    hold_q <= !cnt_if.done;
                end
                default: begin
                    hold_q <= 1'b0;
                end
            endcase
        end
    end

    // Crystal oscillator halts in STOP
    always_ff @(posedge clock) begin
        if (srst) begin
            xosc_en_q <= 1'b1;
        end else if (stop_enter) begin
            xosc_en_q <= 1'b0;
        end else if (stop_leave) begin
            xosc_en_q <= 1'b1;
        end
    end

    // On-chip high-speed oscillator halts in STOP as well
    always_ff @(posedge clock) begin
        if (srst) begin
            ioosc_en_q <= 1'b1;
        end else if (stop_enter) begin
            ioosc_en_q <= 1'b0;
        end else if (stop_leave) begin
            ioosc_en_q <= 1'b1;
        end
    end

    assign mem_rdata = rdata_q;
    assign cpu_hold = hold_q;
    assign crystal_osc_enable = xosc_en_q;
    assign onchip_osc_enable = ioosc_en_q;
endmodule : oscst_top

//--- tb/osc_stabilization_counter_tb_top.sv
// Testbench of the stabilization block
`timescale 1ns/1ns
`include "oscst_cfg.svh"
module osc_stabilization_counter_tb_top;
    typedef struct {logic wr; logic bw; logic [19:0] a; logic [7:0] d; logic [7:0] e;} oscst_row_s;
    localparam logic [19:0] ST = `OSCST_STATUS_ADDR;
    localparam logic [19:0] SL = `OSCST_SELECT_ADDR;
    oscst_row_s rows [7] = '{'{0, 0, ST, 8'h00, 8'h00}, '{0, 0, SL, 8'h00, 8'h07}, '{1, 0, SL, 8'hff, 8'h07},
        '{1, 1, SL, 8'h00, 8'h07}, '{1, 0, SL, 8'h00, 8'h00}, '{1, 0, ST, 8'hff, 8'h00},
        '{0, 0, 20'hfffa4, 8'h00, 8'h00}};
    logic clock = 0, srst = 1, mem_rd = 0, mem_wr = 0, mem_wr_bit = 0, stop_exec = 0, stop_release = 0;
    logic main_osc_stop_set = 0, cpu_on_crystal = 0, xclk, cpu_hold, xen, ien;
    logic [19:0] mem_addr = 0;
    logic [7:0] mem_wdata = 0, mem_rdata;
    int fail_count = 0, n_tests = 0, cyc = 0;
    always #10 clock = ~clock;
    oscst_xtal_model u_oscst_xtal_model (.enable(xen), .xclk(xclk));
    oscst_top u_oscst_top (.clock(clock), .srst(srst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wr_bit(mem_wr_bit), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .stop_exec(stop_exec),
        .stop_release(stop_release), .main_osc_stop_set(main_osc_stop_set), .cpu_on_crystal(cpu_on_crystal),
        .main_crystal_clock(xclk), .cpu_hold(cpu_hold), .crystal_osc_enable(xen), .onchip_osc_enable(ien));
    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic rd(input logic [19:0] a, output logic [7:0] v);
        @(posedge clock) #2 {mem_rd, mem_addr} = {1'b1, a};
        @(posedge clock) #2 mem_rd = 0;
        v = mem_rdata;
    endtask : rd
    task automatic wr(input logic bw, input logic [19:0] a, input logic [7:0] d);
        @(posedge clock) #2 {mem_wr, mem_wr_bit, mem_addr, mem_wdata} = {1'b1, bw, a, d};
        @(posedge clock) #2 mem_wr = 0;
    endtask : wr
    task automatic ev(input logic [2:0] e);
        @(posedge clock) #2 {stop_exec, stop_release, main_osc_stop_set} = e;
        @(posedge clock) #2 {stop_exec, stop_release, main_osc_stop_set} = 3'b000;
    endtask : ev
    always @(posedge clock) begin
        cyc++;
        if (cyc == 15000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        logic [7:0] v;
        repeat (20) @(posedge clock);
        #2 srst = 0;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].bw, rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk(v, rows[i].e);
        end
        $display("register rows done");
        repeat (1600) @(posedge clock);
        rd(ST, v);
        chk(v, 8'h80);
        repeat (3000) @(posedge clock);
        rd(ST, v);
        chk(v, 8'h80);
        $display("count and saturate done");
        cpu_on_crystal = 1;
        ev(3'b100);
        rd(ST, v);
        chk(v, 8'h00);
        chk({7'h00, cpu_hold}, 8'h01);
        chk({6'h00, xen, ien}, 8'h00);
        ev(3'b010);
        repeat (1300) @(posedge clock);
        #2 chk({7'h00, cpu_hold}, 8'h01);
        repeat (300) @(posedge clock);
        #2 chk({7'h00, cpu_hold}, 8'h00);
        chk({6'h00, xen, ien}, 8'h03);
        $display("crystal wake done");
        cpu_on_crystal = 0;
        ev(3'b100);
        ev(3'b010);
        chk({7'h00, cpu_hold}, 8'h00);
        repeat (1600) @(posedge clock);
        rd(ST, v);
        chk(v, 8'h80);
        srst = 1;
        repeat (2) @(posedge clock);
        #2 srst = 0;
        rd(ST, v);
        chk(v, 8'h00);
        rd(SL, v);
        chk(v, 8'h07);
        $display("mid-run reset done");
        ev(3'b001);
        rd(ST, v);
        chk(v, 8'h00);
        $display("on-chip wake and stop bit done");
        tally_and_finish();
    end
endmodule : osc_stabilization_counter_tb_top

//--- tb/oscst_top_checker.sv
// Port assertions of the stabilization block
`timescale 1ns/1ns
`include "oscst_cfg.svh"
module oscst_top_checker (
    input wire logic clock,
    input wire logic srst,
    input wire logic [`OSCST_ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic stop_exec,
    input wire logic stop_release,
    input wire logic cpu_on_crystal,
    input wire logic cpu_hold,
    input wire logic crystal_osc_enable,
    input wire logic onchip_osc_enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic rd_st;
    logic rd_sel;
    assign rd_st = mem_rd && mem_addr == `OSCST_STATUS_ADDR;
    assign rd_sel = mem_rd && mem_addr == `OSCST_SELECT_ADDR;
    sequence s_stop_read;
        stop_exec ##2 rd_st;
    endsequence
    property p_stop_clr; s_stop_read |=> mem_rdata == 8'h00; endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("status not cleared by stop");
    property p_halt; stop_exec |=> cpu_hold && !crystal_osc_enable && !onchip_osc_enable; endproperty
    a_halt: assert property (p_halt) else $error("oscillators run in stop");
    property p_sel_hi; rd_sel |=> mem_rdata[7:3] == 5'h00; endproperty
    a_sel_hi: assert property (p_sel_hi) else $error("select upper bits set");
    property p_unmap; mem_rd && !rd_st && !rd_sel |=> mem_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_idle; !mem_rd |=> mem_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_thermo; rd_st |=> (~mem_rdata & (~mem_rdata + 8'h01)) == 8'h00; endproperty
    a_thermo: assert property (p_thermo) else $error("status not thermometer");
    property p_wait; stop_release && cpu_on_crystal |=> cpu_hold [*8]; endproperty
    a_wait: assert property (p_wait) else $error("crystal wait cut short");
    property p_nowait; stop_release && !cpu_on_crystal |=> !cpu_hold && crystal_osc_enable; endproperty
    a_nowait: assert property (p_nowait) else $error("hold on on-chip clock");
endmodule : oscst_top_checker
bind oscst_top oscst_top_checker u_oscst_top_checker (.clock(clock), .srst(srst), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .stop_exec(stop_exec), .stop_release(stop_release),
    .cpu_on_crystal(cpu_on_crystal), .cpu_hold(cpu_hold), .crystal_osc_enable(crystal_osc_enable),
    .onchip_osc_enable(onchip_osc_enable));

//--- tb/oscst_xtal_model.sv
// Crystal oscillator model with start-up delay
`timescale 1ns/1ns
module oscst_xtal_model #(
    parameter int START_NS = 2000,
    parameter int HALF_NS = 50
) (
    input wire logic enable,
    output logic xclk
);
    always begin
        xclk = 1'b0;
        wait (enable === 1'b1);
        #(START_NS);
        while (enable === 1'b1) begin
            #(HALF_NS) xclk = ~xclk;
        end
    end
endmodule : oscst_xtal_model
